// ### rtl/wrmu_mask_gen.sv
/*
  Contiguous mask generator, doubleword wide, MSB-first position numbering.
  Assumes positions are already offset into the doubleword; purely combinational.
*/
`timescale 1ns/1ps

module wrmu_mask_gen
  import wrmu_pkg::*;
(
  input  wire logic [5:0]  begin_pos_in,
  input  wire logic [5:0]  end_pos_in,
  output logic      [63:0] mask_out
);

  always_comb begin
    logic [5:0] pos;
    pos = 6'h00;
    mask_out = ZERO_DWORD;
    for (int i = 0; i < DWORD_W; i++) begin
      pos = 6'(LAST_POS - 6'(i));
      if (begin_pos_in <= end_pos_in) begin
        mask_out[i] = (pos >= begin_pos_in) && (pos <= end_pos_in);
      end else begin
        mask_out[i] = (pos >= begin_pos_in) || (pos <= end_pos_in);
      end
    end
  end

endmodule

// ### rtl/wrmu_pkg.sv
/*
  Shared constants and types for the word rotate-and-mask unit.
  Assumes a single 100 MHz core clock and one-cycle issue handshake.
*/
package wrmu_pkg;

  localparam int          WORD_W        = 32;
  localparam int          DWORD_W       = 64;
  localparam int          FIELD_W       = 5;
  localparam int          POS_W         = 6;

  // Offset that moves a word field position into the low word of the doubleword
  localparam logic [5:0]  HALF_OFS      = 6'h20;
  localparam logic [5:0]  LAST_POS      = 6'h3F;
  localparam logic [4:0]  WORD_LAST     = 5'h1F;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
  localparam logic [63:0] ZERO_DWORD    = 64'h0000_0000_0000_0000;
  localparam logic [31:0] ONES_WORD     = 32'hFFFF_FFFF;

  // Values after reset
  localparam logic [63:0] RESULT_RST    = 64'h0000_0000_0000_0000;
  localparam logic        FLAG_RST      = 1'h0;
  localparam logic        VALID_RST     = 1'h0;

  // Result appears this many cycles after the issue edge
  localparam int          LATENCY_CYC   = 1;

  typedef enum logic [1:0] {
    OP_INSERT  = 2'b00,
    OP_AND_IMM = 2'b01,
    OP_AND_REG = 2'b10
  } wrmu_op_type;

  // Field (0..31, bit 0 is the word MSB) to doubleword position (bit 0 is MSB)
  function automatic logic [5:0] wrmu_word_pos(input logic [4:0] f);
    wrmu_word_pos = 6'({1'b0, f} + HALF_OFS);
  endfunction

  // Left rotate of a 32-bit word
  function automatic logic [31:0] wrmu_rotl32(input logic [31:0] w, input logic [4:0] n);
    logic [63:0] t;
    t = {w, w} << n;
    wrmu_rotl32 = t[63:32];
  endfunction

endpackage

// ### rtl/wrmu_rotate_mask_unit.sv
/*
  Execution datapath for the three word rotate-then-mask instructions:
  immediate rotate with masked insert, immediate rotate AND mask, and
  register-count rotate AND mask, with optional condition field update.
  Assumes decode presents operands and fields for one cycle with issue valid;
  the result and flags appear registered on the following enabled edge.
*/
`timescale 1ns/1ps

module wrmu_rotate_mask_unit
  import wrmu_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  input  wire logic        issue_valid_in,
  input  wire logic [1:0]  op_sel_in,
  input  wire logic [63:0] source_reg_in,
  input  wire logic [63:0] dest_reg_in,
  input  wire logic [63:0] count_reg_in,
  input  wire logic [4:0]  shift_amount_field_in,
  input  wire logic [4:0]  mask_begin_field_in,
  input  wire logic [4:0]  mask_end_field_in,
  input  wire logic        record_bit_in,
  input  wire logic        summary_ovf_in,
  output logic             result_valid_out,
  output logic      [63:0] dest_reg_out,
  output logic             cond_write_out,
  output logic             less_than_flag_out,
  output logic             greater_than_flag_out,
  output logic             equal_flag_out,
  output logic             summary_ovf_out
);

  wrmu_op_type op;
  logic [4:0]  rot_amt;
  logic [31:0] rot_word;
  logic [63:0] rot_dword;
  logic [5:0]  begin_pos;
  logic [5:0]  end_pos;
  logic [63:0] mask_w;

  logic        valid_r;
  logic        valid_nxt;
  logic [63:0] result_r;
  logic [63:0] result_nxt;
  logic        cond_wr_r;
  logic        cond_wr_nxt;
  logic        lt_r;
  logic        lt_nxt;
  logic        gt_r;
  logic        gt_nxt;
  logic        eq_r;
  logic        eq_nxt;
  logic        so_r;
  logic        so_nxt;

  assign op = wrmu_op_type'(op_sel_in);

  // Rotate stage: only the low word of the source takes part
  always_comb begin
    if (op == OP_AND_REG) begin
      rot_amt = count_reg_in[4:0];
    end else begin
      rot_amt = shift_amount_field_in;
    end
    rot_word  = wrmu_rotl32(source_reg_in[31:0], rot_amt);
    rot_dword = {rot_word, rot_word};
    begin_pos = wrmu_word_pos(mask_begin_field_in);
    end_pos   = wrmu_word_pos(mask_end_field_in);
  end

  wrmu_mask_gen u_mask (
    .begin_pos_in (begin_pos),
    .end_pos_in   (end_pos),
    .mask_out     (mask_w)
  );

  // Result and condition field next values
  always_comb begin
    valid_nxt   = VALID_RST;
    result_nxt  = result_r;
    cond_wr_nxt = FLAG_RST;
    lt_nxt      = lt_r;
    gt_nxt      = gt_r;
    eq_nxt      = eq_r;
    so_nxt      = so_r;
    if (issue_valid_in) begin
      unique case (op)
        OP_INSERT: begin
          // Field inserts fall out of the general merge
          result_nxt = (rot_dword & mask_w) | (dest_reg_in & ~mask_w);
          valid_nxt  = 1'b1;
        end
        OP_AND_IMM: begin
          result_nxt = {ZERO_WORD, rot_word & mask_w[31:0]};
          valid_nxt  = 1'b1;
        end
        OP_AND_REG: begin
          result_nxt = {ZERO_WORD, rot_word & mask_w[31:0]};
          valid_nxt  = 1'b1;
        end
        default: begin
          // Unused operation code: no result, nothing changes
          valid_nxt = VALID_RST;
        end
      endcase
      if (valid_nxt && record_bit_in) begin
        cond_wr_nxt = 1'b1;
        lt_nxt      = $signed(result_nxt) < $signed(ZERO_DWORD);
        gt_nxt      = $signed(result_nxt) > $signed(ZERO_DWORD);
        eq_nxt      = result_nxt == ZERO_DWORD;
        so_nxt      = summary_ovf_in;
      end
    end
  end

  // Register stage; a low clock enable freezes every bit of state
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      valid_r   <= VALID_RST;
      result_r  <= RESULT_RST;
      cond_wr_r <= FLAG_RST;
      lt_r      <= FLAG_RST;
      gt_r      <= FLAG_RST;
      eq_r      <= FLAG_RST;
      so_r      <= FLAG_RST;
    end else if (clk_en_in) begin
      valid_r   <= valid_nxt;
      result_r  <= result_nxt;
      cond_wr_r <= cond_wr_nxt;
      lt_r      <= lt_nxt;
      gt_r      <= gt_nxt;
      eq_r      <= eq_nxt;
      so_r      <= so_nxt;
    end
  end

  assign result_valid_out      = valid_r;
  assign dest_reg_out          = result_r;
  assign cond_write_out        = cond_wr_r;
  assign less_than_flag_out    = lt_r;
  assign greater_than_flag_out = gt_r;
  assign equal_flag_out        = eq_r;
  assign summary_ovf_out       = so_r;

  // Checks

  logic fire;
  assign fire = issue_valid_in && clk_en_in;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_and_upper_clear: assert property (
    fire && op == OP_AND_IMM |=> result_valid_out && dest_reg_out[63:32] == ZERO_WORD
  ) else $error("upper half not cleared on immediate AND");

  a_reg_count_low: assert property (
    fire && op == OP_AND_REG |=> dest_reg_out[63:32] == ZERO_WORD &&
      dest_reg_out[31:0] == (wrmu_rotl32($past(source_reg_in[31:0]),
                                         $past(count_reg_in[4:0]))
                             & $past(mask_w[31:0]))
  ) else $error("register count rotate result wrong");

  a_reg_upper_clear: assert property (
    fire && op == OP_AND_REG && count_reg_in[63:5] != 59'h0
    |=> dest_reg_out[63:32] == ZERO_WORD && result_valid_out
  ) else $error("register form upper half not cleared");

  a_insert_merge: assert property (
    fire && op == OP_INSERT |=>
      (dest_reg_out & ~$past(mask_w)) == ($past(dest_reg_in) & ~$past(mask_w)) &&
      (dest_reg_out & $past(mask_w)) == ($past(rot_dword) & $past(mask_w))
  ) else $error("insert merge wrong");

  a_rotate_pure: assert property (
    fire && (op == OP_AND_IMM || op == OP_AND_REG) && mask_begin_field_in == 5'h00 &&
    mask_end_field_in == WORD_LAST |=>
      dest_reg_out[31:0] ==
        (($past(source_reg_in[31:0]) << $past(rot_amt)) |
         ($past(source_reg_in[31:0]) >> (6'h20 - {1'b0, $past(rot_amt)})))
  ) else $error("pure rotation wrong");

  a_shift_right: assert property (
    fire && op == OP_AND_IMM && shift_amount_field_in != 5'h00 &&
    {1'b0, mask_begin_field_in} == 6'(HALF_OFS - {1'b0, shift_amount_field_in}) &&
    mask_end_field_in == WORD_LAST |=>
      dest_reg_out == {ZERO_WORD,
                       $past(source_reg_in[31:0]) >> $past(mask_begin_field_in)}
  ) else $error("logical right shift wrong");

  a_clear_low: assert property (
    fire && op == OP_AND_IMM && shift_amount_field_in == 5'h00 &&
    mask_begin_field_in == 5'h00 |=>
      dest_reg_out[31:0] == ($past(source_reg_in[31:0]) &
                             (ONES_WORD << (WORD_LAST - $past(mask_end_field_in))))
  ) else $error("clear low bits wrong");

  a_mask_span: assert property (
    mask_begin_field_in <= mask_end_field_in |->
      mask_w[63:32] == ZERO_WORD &&
      mask_w[31 - mask_begin_field_in] && mask_w[31 - mask_end_field_in] &&
      $countones(mask_w) == 32'(mask_end_field_in - mask_begin_field_in) + 1
  ) else $error("mask span wrong");

  a_mask_wrap: assert property (
    mask_begin_field_in > mask_end_field_in |->
      mask_w[63:32] == ONES_WORD &&
      mask_w[31 - mask_begin_field_in] && mask_w[31 - mask_end_field_in] &&
      (mask_w[30 - mask_end_field_in] ==
       ({1'b0, mask_begin_field_in} == {1'b0, mask_end_field_in} + 6'h01))
  ) else $error("wrapped mask wrong");

  a_cond_hold: assert property (
    fire && !record_bit_in |=> !cond_write_out && $stable(less_than_flag_out) &&
      $stable(greater_than_flag_out) && $stable(equal_flag_out) &&
      $stable(summary_ovf_out)
  ) else $error("condition field changed without record bit");

  a_cond_update: assert property (
    fire && record_bit_in && op != 2'b11 |=> cond_write_out &&
      less_than_flag_out == dest_reg_out[63] &&
      equal_flag_out == (dest_reg_out == ZERO_DWORD) &&
      greater_than_flag_out == (!dest_reg_out[63] && dest_reg_out != ZERO_DWORD) &&
      summary_ovf_out == $past(summary_ovf_in)
  ) else $error("condition field update wrong");

  a_freeze_hold: assert property (
    !clk_en_in |=> $stable(dest_reg_out) && $stable(result_valid_out)
  ) else $error("state moved while clock enable low");

  a_valid_pulse: assert property (
    fire && op_sel_in != 2'b11 |=> result_valid_out
  ) else $error("accepted request gave no result");

  a_illegal_drop: assert property (
    fire && op_sel_in == 2'b11 |=> !result_valid_out && !cond_write_out &&
      $stable(dest_reg_out)
  ) else $error("illegal operation code changed state");

  a_idle_drop: assert property (
    clk_en_in && !issue_valid_in |=> !result_valid_out && !cond_write_out &&
      $stable(dest_reg_out)
  ) else $error("result changed without a request");

  a_cond_pulse: assert property (
    cond_write_out |-> result_valid_out
  ) else $error("condition write without a result");

  a_imm_rotate: assert property (
    fire && op == OP_AND_IMM |=>
      dest_reg_out[31:0] == ((($past(source_reg_in[31:0]) << $past(shift_amount_field_in)) |
        ($past(source_reg_in[31:0]) >> (6'h20 - {1'b0, $past(shift_amount_field_in)}))) &
        $past(mask_w[31:0]))
  ) else $error("immediate rotate result wrong");

  a_insert_upper: assert property (
    fire && op == OP_INSERT && mask_begin_field_in <= mask_end_field_in |=>
      dest_reg_out[63:32] == $past(dest_reg_in[63:32])
  ) else $error("insert disturbed the upper half");

  a_insert_left: assert property (
    fire && op == OP_INSERT && mask_begin_field_in != 5'h00 &&
    mask_begin_field_in <= mask_end_field_in &&
    {1'b0, shift_amount_field_in} == 6'(HALF_OFS - {1'b0, mask_begin_field_in}) |=>
      (dest_reg_out[31:0] & $past(mask_w[31:0])) ==
        (($past(source_reg_in[31:0]) >> $past(mask_begin_field_in)) & $past(mask_w[31:0]))
  ) else $error("left-justified field insert wrong");

  a_insert_right: assert property (
    fire && op == OP_INSERT && mask_begin_field_in <= mask_end_field_in &&
    shift_amount_field_in == 5'(WORD_LAST - mask_end_field_in) |=>
      (dest_reg_out[31:0] & $past(mask_w[31:0])) ==
        (($past(source_reg_in[31:0]) << $past(shift_amount_field_in)) & $past(mask_w[31:0]))
  ) else $error("right-justified field insert wrong");

  a_reg_extract: assert property (
    fire && op == OP_AND_REG && count_reg_in[4:0] != 5'h00 &&
    mask_end_field_in == WORD_LAST &&
    {1'b0, count_reg_in[4:0]} >= 6'(HALF_OFS - {1'b0, mask_begin_field_in}) |=>
      dest_reg_out[63:32] == ZERO_WORD &&
      dest_reg_out[31:0] == (($past(source_reg_in[31:0]) >>
                              (6'h20 - {1'b0, $past(count_reg_in[4:0])})) &
                             (ONES_WORD >> $past(mask_begin_field_in)))
  ) else $error("variable field extract wrong");

  a_mask_full: assert property (
    mask_begin_field_in == 5'h00 && mask_end_field_in == WORD_LAST |->
      mask_w == {ZERO_WORD, ONES_WORD}
  ) else $error("full word mask wrong");

endmodule

// ### sim/wrmu_issue_model.sv
/*
  Issue-stage model: presents one request per call and holds it to an enabled edge.
  Assumes issue is entered just after a rising clock edge.
*/
`timescale 1ns/1ps

module wrmu_issue_model (
  input  wire logic        core_clk_in,
  input  wire logic        clk_en_in,
  output logic             issue_valid_out,
  output logic      [1:0]  op_sel_out,
  output logic      [63:0] source_reg_out,
  output logic      [63:0] dest_reg_out,
  output logic      [63:0] count_reg_out,
  output logic      [4:0]  shift_amount_field_out,
  output logic      [4:0]  mask_begin_field_out,
  output logic      [4:0]  mask_end_field_out,
  output logic             record_bit_out,
  output logic             summary_ovf_out
);
  initial begin
    {issue_valid_out, op_sel_out, source_reg_out, dest_reg_out, count_reg_out} = '0;
    {shift_amount_field_out, mask_begin_field_out, mask_end_field_out} = '0;
    {record_bit_out, summary_ovf_out} = '0;
  end

  task automatic issue(input logic [1:0] op, input logic [63:0] s, d, c,
                       input logic [4:0] sh, mb, me, input logic rec, so);
    issue_valid_out <= 1'h1;
    {op_sel_out, source_reg_out, dest_reg_out, count_reg_out} <= {op, s, d, c};
    {shift_amount_field_out, mask_begin_field_out, mask_end_field_out} <= {sh, mb, me};
    {record_bit_out, summary_ovf_out} <= {rec, so};
    do @(posedge core_clk_in); while (clk_en_in !== 1'h1);
  endtask

  // Released operands are inverted on each idle call so stale values never pass
  task automatic idle();
    issue_valid_out <= 1'h0;
    {source_reg_out, dest_reg_out} <= ~{source_reg_out, dest_reg_out};
    count_reg_out <= ~count_reg_out;
  endtask
endmodule

// ### sim/wrmu_rotate_mask_unit_tb_top.sv
/*
  Self-checking bench for the rotate-and-mask unit with a result scoreboard.
  Assumes a one enabled cycle result latency and op code 11 refused.
*/
`timescale 1ns/1ps

module wrmu_rotate_mask_unit_tb_top
  import wrmu_pkg::*;
;
  `define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end

  logic        clk = 1'h0, rst = 1'h1, en = 1'h1, en_q = 1'h0, rnd_en = 1'h0;
  logic        iv, rec, so_i, rv, cw, lt, gt, eq, so_o;
  logic [1:0]  op;
  logic [63:0] src, dst, cnt, res;
  logic [4:0]  sh, mb, me;
  logic [3:0]  fl = 4'h0;
  logic [68:0] expq[$];
  logic [68:0] e;
  int          err_total = 0, comparisons = 0, cyc = 0;

  always #5 clk = ~clk;

  wrmu_issue_model u_wrmu_issue_model (.core_clk_in(clk), .clk_en_in(en),
    .issue_valid_out(iv), .op_sel_out(op), .source_reg_out(src), .dest_reg_out(dst),
    .count_reg_out(cnt), .shift_amount_field_out(sh), .mask_begin_field_out(mb),
    .mask_end_field_out(me), .record_bit_out(rec), .summary_ovf_out(so_i));

  wrmu_rotate_mask_unit u_wrmu_rotate_mask_unit (.core_clk_in(clk), .rst_in(rst),
    .clk_en_in(en), .issue_valid_in(iv), .op_sel_in(op), .source_reg_in(src),
    .dest_reg_in(dst), .count_reg_in(cnt), .shift_amount_field_in(sh),
    .mask_begin_field_in(mb), .mask_end_field_in(me), .record_bit_in(rec),
    .summary_ovf_in(so_i), .result_valid_out(rv), .dest_reg_out(res),
    .cond_write_out(cw), .less_than_flag_out(lt), .greater_than_flag_out(gt),
    .equal_flag_out(eq), .summary_ovf_out(so_o));

  function automatic logic [63:0] model(logic [1:0] o, logic [63:0] s, d, c,
                                        logic [4:0] a, b5, e5);
    logic [4:0]  n;
    logic [31:0] r;
    logic [63:0] m;
    int          b, f;
    n = (o == OP_AND_REG) ? c[4:0] : a;
    r = (s[31:0] << n) | (s[31:0] >> (6'h20 - n));
    b = b5 + 32;
    f = e5 + 32;
    for (int k = 0; k < 64; k++) m[63-k] = (b <= f) ? (k >= b && k <= f) : (k >= b || k <= f);
    return (o == OP_INSERT) ? ({r, r} & m) | (d & ~m) : {ZERO_WORD, r & m[31:0]};
  endfunction

  task automatic req(logic [1:0] o, logic [63:0] s, d, c, logic [4:0] a, b, f, logic rc);
    logic [63:0] r;
    logic        so;
    r = model(o, s, d, c, a, b, f);
    so = 1'($urandom);
    if (o != 2'h3) begin
      if (rc) fl = {$signed(r) < 0, $signed(r) > 0, r == ZERO_DWORD, so};
      expq.push_back({r, rc, fl});
    end
    u_wrmu_issue_model.issue(o, s, d, c, a, b, f, rc, so);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk) begin
    en_q <= en;
    cyc++;
    if (rnd_en) en <= 1'($urandom);
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  always @(negedge clk) begin
    if (en_q && rv === 1'h1) begin
      e = (expq.size() > 0) ? expq.pop_front() : 'x;
      `CMP({res, cw, lt, gt, eq, so_o}, e)
    end
  end

  initial begin
    void'($urandom(84));
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    req(OP_INSERT, 64'hFFFF_FFFF_AB00_0000, 64'h8000_0000_0000_0000, 0, 28, 4, 11, 1);
    req(OP_INSERT, 64'h0000_0000_0000_00CD, 64'h1234_5678_9ABC_DEF0, 0, 20, 4, 11, 0);
    req(OP_AND_IMM, 64'hFFFF_FFFF_1234_5678, 0, 0, 4, 0, 31, 1);
    req(OP_AND_REG, 64'h0000_0000_1234_5678, 0, 64'hFFFF_FFFF_FFFF_FFFC, 0, 0, 31, 1);
    req(OP_AND_IMM, 64'h0000_0000_8765_4321, 0, 0, 24, 8, 31, 0);
    req(OP_AND_IMM, 64'h0000_0000_8765_4321, 0, 0, 0, 0, 23, 1);
    req(OP_AND_REG, 64'h0000_0000_0FF0_0000, 0, 64'hFFFF_FFFF_FFFF_FFEC, 0, 24, 31, 1);
    req(OP_INSERT, 64'h0000_0000_F0F0_F0F0, 64'h0000_0000_1111_1111, 0, 3, 28, 3, 1);
    req(OP_AND_IMM, 64'h0000_0000_F0F0_F0F0, 0, 0, 3, 28, 3, 1);
    req(2'h3, 64'h0000_0000_FFFF_FFFF, 0, 0, 0, 0, 31, 1);
    req(OP_AND_IMM, 0, 0, 0, 0, 0, 31, 1);
    rnd_en = 1'h1;
    repeat (300) begin
      req(2'($urandom), {$urandom, $urandom}, {$urandom, $urandom}, {$urandom, $urandom},
          5'($urandom), 5'($urandom), 5'($urandom), 1'($urandom));
      if ($urandom_range(3) == 0) begin
        u_wrmu_issue_model.idle();
        @(posedge clk);
      end
    end
    rnd_en = 1'h0;
    en <= 1'h1;
    u_wrmu_issue_model.idle();
    repeat (5) @(posedge clk);
    `CMP(expq.size(), 0)
    print_verdict();
  end
endmodule
